// File: verilog/edoc_ctrl.v
/*
  Controller that drives an asynchronous extended-output-page dynamic memory:
  power-up, word/byte reads and writes, page bursts, timed counter refresh, self refresh.
  Assumes the memory pins are driven straight from flops and data in passes a 2-flop sync.
*/
`timescale 1ns/100ps
`include "edoc_defs.vh"
module edoc_ctrl #(
  parameter REFRESH_CYC = `EDOC_REFRESH_CYC,
  parameter POWERUP_CYC = `EDOC_POWERUP_CYC,
  parameter SELF_HOLD_CYC = `EDOC_SELF_HOLD_CYC
) (
  input wire clk_i,
  input wire rst_i,
  input wire req_valid_i,
  input wire req_write_i,
  input wire req_last_i,
  input wire [1:0] req_byte_en_i,
  input wire [9:0] req_row_i,
  input wire [9:0] req_col_i,
  input wire [15:0] req_wdata_i,
  input wire self_refresh_i,
  input wire [15:0] mem_dq_i,
  output reg req_ready_o,
  output reg rsp_valid_o,
  output reg [15:0] rsp_rdata_o,
  output reg init_done_o,
  output reg in_self_refresh_o,
  output reg row_strobe_n_o,
  output reg lower_byte_column_strobe_n_o,
  output reg upper_byte_column_strobe_n_o,
  output reg write_enable_n_o,
  output reg output_enable_n_o,
  output reg [9:0] mem_addr_o,
  output reg [15:0] mem_dq_o,
  output reg mem_dq_oe_n_o
);
  localparam W = `EDOC_CNT_W;
  // Counts kept 32 bits wide and sliced at use, so no bits are dropped silently
  localparam [31:0] ACT_CYC32 = `EDOC_T_ACTIVE_CYC;
  localparam [31:0] RTC_CYC32 = `EDOC_T_ROW_TO_COL_CYC;
  localparam [31:0] INIT_CYC32 = `EDOC_INIT_CYCLES;
  localparam [3:0] S_PWR = 4'h0, S_INIT = 4'h1, S_IDLE = 4'h2, S_ROW = 4'h3, S_COL = 4'h4,
    S_COLEND = 4'h5, S_CLOSE = 4'h6, S_PRE = 4'h7, S_CBR = 4'h8, S_SELF = 4'h9;
  reg [3:0] st_q;
  reg [15:0] sync1_q, sync2_q;
  reg [31:0] ref_cnt_q;
  reg ref_pend_q;
  reg [3:0] init_cnt_q;
  reg write_q;
  reg last_q;
  reg tload;
  reg [W-1:0] tval;
  wire tdone;
  reg [31:0] pwr_cnt_q;
  reg act_load;
  wire act_done;

  edoc_timer #(.W(W)) u_wait (.clk_i(clk_i), .rst_i(rst_i), .load_i(tload), .value_i(tval), .done_o(tdone));
  // Separate timer guards minimum row-low time across the page
  edoc_timer #(.W(W)) u_act (.clk_i(clk_i), .rst_i(rst_i), .load_i(act_load),
    .value_i(ACT_CYC32[W-1:0]), .done_o(act_done));

  // Data pins come from outside the clock domain
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= 16'h0000;
      sync2_q <= 16'h0000;
    end else begin
      sync1_q <= mem_dq_i;
      sync2_q <= sync1_q;
    end
  end

  // Distributed refresh timer; pending flag set wins over clear
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_cnt_q <= 32'h0000_0000;
      ref_pend_q <= 1'b0;
    end else begin
      if (ref_cnt_q >= REFRESH_CYC - 1) begin
        ref_cnt_q <= 32'h0000_0000;
        ref_pend_q <= 1'b1;
      end else begin
        ref_cnt_q <= ref_cnt_q + 32'h0000_0001;
        if (st_q == S_CBR && tdone)
          ref_pend_q <= 1'b0;
      end
    end
  end

  always @* begin
    tload = 1'b0;
    tval = {W{1'b0}};
    act_load = 1'b0;
    case (st_q)
      // Mirrors the idle priority below: refresh and self refresh win over access
      S_IDLE: if (tdone && !ref_pend_q && !self_refresh_i && req_valid_i && init_done_o) begin
        tload = 1'b1;
        tval = RTC_CYC32[W-1:0];
        act_load = 1'b1;
      end
      default: ;
    endcase
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_q <= S_PWR;
      pwr_cnt_q <= 32'h0000_0000;
      init_cnt_q <= 4'h0;
      write_q <= 1'b0;
      last_q <= 1'b1;
      req_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= 16'h0000;
      init_done_o <= 1'b0;
      in_self_refresh_o <= 1'b0;
      row_strobe_n_o <= 1'b1;
      lower_byte_column_strobe_n_o <= 1'b1;
      upper_byte_column_strobe_n_o <= 1'b1;
      write_enable_n_o <= 1'b1;
      output_enable_n_o <= 1'b1;
      mem_addr_o <= 10'h000;
      mem_dq_o <= 16'h0000;
      mem_dq_oe_n_o <= 1'b1;
    end else begin
      rsp_valid_o <= 1'b0;
      req_ready_o <= 1'b0;
      pwr_cnt_q <= pwr_cnt_q + 32'h0000_0001;
      case (st_q)
        S_PWR: if (pwr_cnt_q >= POWERUP_CYC) begin
          st_q <= S_INIT;
          pwr_cnt_q <= 32'h0000_0000;
        end
        S_INIT: begin
          // Wake-up cycles are counter refreshes so no address is needed
          if (init_cnt_q == INIT_CYC32[3:0]) begin
            init_done_o <= 1'b1;
            st_q <= S_IDLE;
          end else begin
            init_cnt_q <= init_cnt_q + 4'h1;
            lower_byte_column_strobe_n_o <= 1'b0;
            upper_byte_column_strobe_n_o <= 1'b0;
            pwr_cnt_q <= 32'h0000_0000;
            st_q <= S_CBR;
          end
        end
        S_IDLE: begin
          // Refresh takes priority at cycle boundaries only
          if (ref_pend_q || (self_refresh_i && init_done_o)) begin
            lower_byte_column_strobe_n_o <= 1'b0;
            upper_byte_column_strobe_n_o <= 1'b0;
            mem_dq_oe_n_o <= 1'b1;
            pwr_cnt_q <= 32'h0000_0000;
            st_q <= S_CBR;
          end else if (req_valid_i && init_done_o && tdone) begin
            mem_addr_o <= req_row_i;
            row_strobe_n_o <= 1'b0;
            st_q <= S_ROW;
          end
        end
        S_ROW: if (tdone) begin
          mem_addr_o <= req_col_i;
          st_q <= S_COL;
        end
        S_COL: begin
          write_q <= req_write_i;
          last_q <= req_last_i;
          if (req_write_i) begin
            mem_dq_o <= req_wdata_i;
            mem_dq_oe_n_o <= 1'b0;
            write_enable_n_o <= 1'b0;
            output_enable_n_o <= 1'b1;
          end else begin
            mem_dq_oe_n_o <= 1'b1;
            write_enable_n_o <= 1'b1;
            output_enable_n_o <= 1'b0;
          end
          lower_byte_column_strobe_n_o <= ~req_byte_en_i[0];
          upper_byte_column_strobe_n_o <= ~req_byte_en_i[1];
          req_ready_o <= 1'b1;
          pwr_cnt_q <= 32'h0000_0000;
          st_q <= S_COLEND;
        end
        S_COLEND: if (pwr_cnt_q >= `EDOC_T_ROW_ACCESS_CYC - 1) begin
          if (!write_q) begin
            rsp_rdata_o <= sync2_q;
            rsp_valid_o <= 1'b1;
          end
          lower_byte_column_strobe_n_o <= 1'b1;
          upper_byte_column_strobe_n_o <= 1'b1;
          write_enable_n_o <= 1'b1;
          mem_dq_oe_n_o <= 1'b1;
          st_q <= S_CLOSE;
        end
        S_CLOSE: begin
          // Row stays open for the next column until the taken one was last; a due refresh closes it
          if (req_valid_i && !last_q && !ref_pend_q && !write_q) begin
            mem_addr_o <= req_col_i;
            st_q <= S_COL;
          end else if (req_valid_i && !last_q && !ref_pend_q) begin
            mem_addr_o <= req_col_i;
            st_q <= S_COL;
          end else if (act_done && (last_q || ref_pend_q || self_refresh_i)) begin
            row_strobe_n_o <= 1'b1;
            output_enable_n_o <= 1'b1;
            pwr_cnt_q <= 32'h0000_0000;
            st_q <= S_PRE;
          end
        end
        // Wake-up refreshes return to the init counter, not to idle
        S_PRE: if (pwr_cnt_q >= `EDOC_T_PRECHARGE_CYC - 1) st_q <= init_done_o ? S_IDLE : S_INIT;
        S_CBR: begin
          // Column strobes settle low one cycle before the row strobe falls
          row_strobe_n_o <= 1'b0;
          if (pwr_cnt_q >= `EDOC_T_ACTIVE_CYC && self_refresh_i && init_done_o) begin
            st_q <= S_SELF;
            pwr_cnt_q <= 32'h0000_0000;
          end else if (pwr_cnt_q >= `EDOC_T_ACTIVE_CYC) begin
            row_strobe_n_o <= 1'b1;
            lower_byte_column_strobe_n_o <= 1'b1;
            upper_byte_column_strobe_n_o <= 1'b1;
            pwr_cnt_q <= 32'h0000_0000;
            st_q <= S_PRE;
          end
        end
        S_SELF: begin
          if (pwr_cnt_q >= SELF_HOLD_CYC) in_self_refresh_o <= 1'b1;
          if (!self_refresh_i && pwr_cnt_q >= SELF_HOLD_CYC) begin
            row_strobe_n_o <= 1'b1;
            lower_byte_column_strobe_n_o <= 1'b1;
            upper_byte_column_strobe_n_o <= 1'b1;
            in_self_refresh_o <= 1'b0;
            pwr_cnt_q <= 32'h0000_0000;
            st_q <= S_PRE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end
endmodule

// File: common/edoc_defs.vh
/*
  Timing constants for the extended-output-page memory controller.
  Assumes a 40 MHz clock (25 ns); all counts except EDOC_INIT_CYCLES are derived from times in ns.
*/
`ifndef EDOC_DEFS_VH
`define EDOC_DEFS_VH

`define EDOC_CLK_NS 25
// Access windows (minimum, rounded up)
`define EDOC_T_ACTIVE_NS 60
`define EDOC_T_ACTIVE_CYC ((`EDOC_T_ACTIVE_NS + `EDOC_CLK_NS - 1) / `EDOC_CLK_NS)
`define EDOC_T_PRECHARGE_NS 40
`define EDOC_T_PRECHARGE_CYC ((`EDOC_T_PRECHARGE_NS + `EDOC_CLK_NS - 1) / `EDOC_CLK_NS)
`define EDOC_T_ROW_TO_COL_NS 14
`define EDOC_T_ROW_TO_COL_CYC ((`EDOC_T_ROW_TO_COL_NS + `EDOC_CLK_NS - 1) / `EDOC_CLK_NS)
`define EDOC_T_ROW_ACCESS_NS 60
`define EDOC_T_ROW_ACCESS_CYC ((`EDOC_T_ROW_ACCESS_NS + `EDOC_CLK_NS - 1) / `EDOC_CLK_NS)
`define EDOC_T_COL_STROBE_NS 15
`define EDOC_T_COL_STROBE_CYC ((`EDOC_T_COL_STROBE_NS + `EDOC_CLK_NS - 1) / `EDOC_CLK_NS)
`define EDOC_T_COL_PRE_NS 10
`define EDOC_T_COL_PRE_CYC ((`EDOC_T_COL_PRE_NS + `EDOC_CLK_NS - 1) / `EDOC_CLK_NS)
// Refresh: 1,024 rows per 16 ms, longest spacing rounded down
`define EDOC_ROWS 1024
`define EDOC_RETENTION_US 16000
`define EDOC_REFRESH_NS ((`EDOC_RETENTION_US * 1000) / `EDOC_ROWS)
`define EDOC_REFRESH_CYC (`EDOC_REFRESH_NS / `EDOC_CLK_NS)
// Power-up pause and wake-up cycles
`define EDOC_POWERUP_US 200
`define EDOC_POWERUP_CYC ((`EDOC_POWERUP_US * 1000) / `EDOC_CLK_NS)
`define EDOC_INIT_CYCLES 8
// Self refresh hold, minimum
`define EDOC_SELF_HOLD_US 100
`define EDOC_SELF_HOLD_CYC ((`EDOC_SELF_HOLD_US * 1000) / `EDOC_CLK_NS)
`define EDOC_CNT_W 16

`endif

// File: verilog/edoc_timer.v
/*
  Down-counting wait timer used for the row-to-column and row-active delays.
  Assumes load and count share clk_i; load wins over counting.
*/
`timescale 1ns/100ps
module edoc_timer #(
  parameter W = 16
) (
  input wire clk_i,
  input wire rst_i,
  input wire load_i,
  input wire [W-1:0] value_i,
  output reg done_o
);
  reg [W-1:0] cnt_q;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= {W{1'b0}};
      done_o <= 1'b1;
    end else if (load_i) begin
      cnt_q <= value_i;
      done_o <= (value_i == {W{1'b0}});
    end else if (cnt_q != {W{1'b0}}) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      done_o <= (cnt_q == {{(W-1){1'b0}}, 1'b1});
    end
  end
endmodule

// File: verif/edoc_ctrl_asserts.sv
/* Port checker for edoc_ctrl: strobe timing, boot order, refresh spacing.
   Assumes it is bound onto edoc_ctrl and sees one clock domain. */
`timescale 1ns/100ps
module edoc_chk #(
  parameter REFRESH_CYC = 625,
  parameter POWERUP_CYC = 8000
) (
  input wire clk_i,
  input wire rst_i,
  input wire init_done_o,
  input wire in_self_refresh_o,
  input wire row_strobe_n_o,
  input wire lower_byte_column_strobe_n_o,
  input wire upper_byte_column_strobe_n_o,
  input wire write_enable_n_o,
  input wire output_enable_n_o,
  input wire [9:0] mem_addr_o,
  input wire mem_dq_oe_n_o
);
  reg ras_q;
  reg [15:0] cyc_q;
  reg [3:0] falls_q;
  reg [15:0] gap_q;
  reg cbr_q;
  wire cas_n = lower_byte_column_strobe_n_o & upper_byte_column_strobe_n_o;
  wire fall_w = ras_q & ~row_strobe_n_o;
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ras_q <= 1'b1;
      cyc_q <= 16'h0000;
      falls_q <= 4'h0;
      gap_q <= 16'h0000;
      cbr_q <= 1'b0;
    end else begin
      ras_q <= row_strobe_n_o;
      if (cyc_q != 16'hffff)
        cyc_q <= cyc_q + 16'h0001;
      if (fall_w && falls_q != 4'hf)
        falls_q <= falls_q + 4'h1;
      if (fall_w)
        cbr_q <= ~cas_n;
      // A held counter refresh or self refresh keeps rows alive, so the interval restarts
      if (in_self_refresh_o || (fall_w && !cas_n) || (cbr_q && !row_strobe_n_o))
        gap_q <= 16'h0000;
      else
        gap_q <= gap_q + 16'h0001;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_act; $fell(row_strobe_n_o) |-> !row_strobe_n_o [*3]; endproperty
  a_act: assert property (p_act) else $error("row strobe low too short");
  property p_pre; $rose(row_strobe_n_o) |-> row_strobe_n_o [*2]; endproperty
  a_pre: assert property (p_pre) else $error("precharge too short");
  property p_wdat; !write_enable_n_o && !cas_n |-> !mem_dq_oe_n_o; endproperty
  a_wdat: assert property (p_wdat) else $error("write data not driven");
  property p_addr; !cas_n && !$past(cas_n) && !output_enable_n_o |-> $stable(mem_addr_o); endproperty
  a_addr: assert property (p_addr) else $error("column address moved");
  property p_boot; $rose(init_done_o) |-> cyc_q >= POWERUP_CYC && falls_q >= 4'h8; endproperty
  a_boot: assert property (p_boot) else $error("ready before wake-up");
  property p_quiet; !init_done_o |-> write_enable_n_o && mem_dq_oe_n_o; endproperty
  a_quiet: assert property (p_quiet) else $error("access before ready");
  property p_ref; init_done_o && !in_self_refresh_o |-> gap_q <= REFRESH_CYC + 40; endproperty
  a_ref: assert property (p_ref) else $error("refresh overdue");
  property p_cbr; $fell(row_strobe_n_o) && !cas_n |-> mem_dq_oe_n_o && output_enable_n_o; endproperty
  a_cbr: assert property (p_cbr) else $error("bus used in counter refresh");
  c_cbr: cover property ($fell(row_strobe_n_o) && !cas_n);
  c_wr: cover property (!write_enable_n_o && !cas_n);
  c_self: cover property ($rose(in_self_refresh_o));
endmodule
bind edoc_ctrl edoc_chk #(.REFRESH_CYC(REFRESH_CYC), .POWERUP_CYC(POWERUP_CYC)) chk_u (
  .clk_i(clk_i), .rst_i(rst_i), .init_done_o(init_done_o), .in_self_refresh_o(in_self_refresh_o),
  .row_strobe_n_o(row_strobe_n_o), .lower_byte_column_strobe_n_o(lower_byte_column_strobe_n_o),
  .upper_byte_column_strobe_n_o(upper_byte_column_strobe_n_o), .write_enable_n_o(write_enable_n_o),
  .output_enable_n_o(output_enable_n_o), .mem_addr_o(mem_addr_o), .mem_dq_oe_n_o(mem_dq_oe_n_o)
);

// File: verif/edoc_mem_model.sv
/* Behavioural page-mode memory on the far side of edoc_ctrl.
   Assumes the bench resolves the shared data bus; 32 rows x 32 columns kept. */
`timescale 1ns/100ps
module edoc_mem_model (
  input wire row_strobe_n_i,
  input wire lower_byte_column_strobe_n_i,
  input wire upper_byte_column_strobe_n_i,
  input wire write_enable_n_i,
  input wire output_enable_n_i,
  input wire [9:0] addr_i,
  input wire [15:0] dq_i,
  output wire [15:0] dq_o
);
  reg [15:0] mem [0:1023];
  reg [9:0] row_q;
  reg [9:0] cnt_q = 10'h000;
  reg [15:0] dout_q = 16'h0000;
  reg [1:0] lane_q = 2'h0;
  reg drv_q = 1'b0;
  integer cbr_cnt = 0;
  wire lo_n = lower_byte_column_strobe_n_i;
  wire hi_n = upper_byte_column_strobe_n_i;
  wire cas_n = lo_n & hi_n;
  wire [9:0] ix = {row_q[4:0], addr_i[4:0]};
  // Released lanes show the inverse so a late sample never looks valid
  assign dq_o[7:0] = (drv_q && lane_q[0] && !output_enable_n_i) ? dout_q[7:0] : ~dout_q[7:0];
  assign dq_o[15:8] = (drv_q && lane_q[1] && !output_enable_n_i) ? dout_q[15:8] : ~dout_q[15:8];
  always @(negedge row_strobe_n_i) begin
    #1;
    if (!cas_n) begin
      cbr_cnt = cbr_cnt + 1;
      row_q = cnt_q;
      cnt_q = cnt_q + 10'h001;
    end else
      row_q = addr_i;
  end
  always @(negedge cas_n)
    drv_q = 1'b0;
  always @(posedge row_strobe_n_i or posedge cas_n)
    if (row_strobe_n_i && cas_n)
      drv_q = 1'b0;
  always @(negedge cas_n or negedge output_enable_n_i) begin
    #1;
    if (!row_strobe_n_i && !cas_n && !output_enable_n_i && write_enable_n_i) begin
      lane_q = {~hi_n, ~lo_n};
      dout_q <= #20 mem[ix];
      drv_q <= #20 1'b1;
    end
  end
  always @(negedge cas_n or negedge write_enable_n_i) begin
    #1;
    if (!row_strobe_n_i && !cas_n && !write_enable_n_i) begin
      if (!lo_n)
        mem[ix][7:0] = dq_i[7:0];
      if (!hi_n)
        mem[ix][15:8] = dq_i[15:8];
    end
  end
endmodule

// File: verif/edoc_ctrl_tb.sv
/* Self-checking bench for edoc_ctrl against the behavioural memory.
   Assumes short pause, refresh and hold counts set below. */
`timescale 1ns/100ps
module edoc_ctrl_tb;
  localparam RC = 200;
  localparam SH = 10;
  reg clk_i = 1'b0;
  reg rst_i = 1'b1;
  reg req_valid_i = 1'b0, req_write_i = 1'b0, req_last_i = 1'b0, self_refresh_i = 1'b0;
  reg [1:0] req_byte_en_i = 2'h0;
  reg [9:0] req_row_i = 10'h000, req_col_i = 10'h000;
  reg [15:0] req_wdata_i = 16'h0000, got;
  wire req_ready_o, rsp_valid_o, init_done_o, in_self_refresh_o, ras_n, lo_n, hi_n, we_n, oe_n, dq_oe_n;
  wire [15:0] rsp_rdata_o, mem_dq_o, mdl_dq, dq_w;
  wire [9:0] mem_addr_o;
  integer error_cnt = 0, checks = 0, n0;
  assign dq_w = dq_oe_n ? mdl_dq : mem_dq_o;
  edoc_ctrl #(.REFRESH_CYC(RC), .POWERUP_CYC(20), .SELF_HOLD_CYC(SH)) dut_u (
    .clk_i(clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i), .req_write_i(req_write_i),
    .req_last_i(req_last_i), .req_byte_en_i(req_byte_en_i), .req_row_i(req_row_i), .req_col_i(req_col_i),
    .req_wdata_i(req_wdata_i), .self_refresh_i(self_refresh_i), .mem_dq_i(dq_w), .req_ready_o(req_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_rdata_o(rsp_rdata_o), .init_done_o(init_done_o),
    .in_self_refresh_o(in_self_refresh_o), .row_strobe_n_o(ras_n), .lower_byte_column_strobe_n_o(lo_n),
    .upper_byte_column_strobe_n_o(hi_n), .write_enable_n_o(we_n), .output_enable_n_o(oe_n),
    .mem_addr_o(mem_addr_o), .mem_dq_o(mem_dq_o), .mem_dq_oe_n_o(dq_oe_n));
  edoc_mem_model mdl_u (.row_strobe_n_i(ras_n), .lower_byte_column_strobe_n_i(lo_n),
    .upper_byte_column_strobe_n_i(hi_n), .write_enable_n_i(we_n), .output_enable_n_i(oe_n),
    .addr_i(mem_addr_o), .dq_i(dq_w), .dq_o(mdl_dq));
  initial forever #12.5 clk_i = ~clk_i;
  task chk(input string name, input [15:0] seen, input [15:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task req(input w, input l, input [1:0] be, input [9:0] r, input [9:0] c, input [15:0] d);
    integer n;
    begin
      @(posedge clk_i);
      #2;
      {req_valid_i, req_write_i, req_last_i, req_byte_en_i} = {1'b1, w, l, be};
      {req_row_i, req_col_i, req_wdata_i} = {r, c, d};
      n = 0;
      @(posedge clk_i);
      while (req_ready_o !== 1'b1 && n < 400) begin
        @(posedge clk_i);
        n = n + 1;
      end
      #2;
      req_valid_i = 1'b0;
      while (!w && rsp_valid_o !== 1'b1 && n < 420) begin
        @(posedge clk_i);
        n = n + 1;
      end
      got = rsp_rdata_o;
      chk("handshake", {15'h0000, n < 400}, 16'h0001);
    end
  endtask
  task t_word;
    req(1'b1, 1'b1, 2'h3, 10'h003, 10'h005, 16'ha5c3);
    req(1'b0, 1'b1, 2'h3, 10'h003, 10'h005, 16'h0000);
    chk("word", got, 16'ha5c3);
    req(1'b1, 1'b1, 2'h1, 10'h003, 10'h005, 16'h1e2d);
    req(1'b1, 1'b1, 2'h2, 10'h003, 10'h005, 16'h7700);
    req(1'b0, 1'b1, 2'h3, 10'h003, 10'h005, 16'h0000);
    chk("byte", got, 16'h772d);
  endtask
  task t_page;
    req(1'b1, 1'b0, 2'h3, 10'h009, 10'h001, 16'h1234);
    req(1'b1, 1'b0, 2'h3, 10'h009, 10'h002, 16'h5678);
    req(1'b0, 1'b0, 2'h3, 10'h009, 10'h001, 16'h0000);
    chk("page1", got, 16'h1234);
    req(1'b0, 1'b1, 2'h3, 10'h009, 10'h002, 16'h0000);
    chk("page2", got, 16'h5678);
  endtask
  task t_ref;
    n0 = mdl_u.cbr_cnt;
    repeat (2 * RC + 60) @(posedge clk_i);
    chk("refresh", {15'h0000, mdl_u.cbr_cnt - n0 >= 2}, 16'h0001);
    req(1'b0, 1'b1, 2'h3, 10'h003, 10'h005, 16'h0000);
    chk("keep", got, 16'h772d);
  endtask
  task t_self;
    integer n;
    begin
      n0 = mdl_u.cbr_cnt;
      #2;
      self_refresh_i = 1'b1;
      for (n = 0; n < 400 && in_self_refresh_o !== 1'b1; n = n + 1)
        @(posedge clk_i);
      chk("self_in", {15'h0000, in_self_refresh_o === 1'b1 && mdl_u.cbr_cnt > n0}, 16'h0001);
      repeat (SH + 20) @(posedge clk_i);
      #2;
      self_refresh_i = 1'b0;
      for (n = 0; n < 400 && in_self_refresh_o !== 1'b0; n = n + 1)
        @(posedge clk_i);
      chk("self_out", {15'h0000, in_self_refresh_o}, 16'h0000);
      req(1'b0, 1'b1, 2'h3, 10'h009, 10'h002, 16'h0000);
      chk("self_keep", got, 16'h5678);
    end
  endtask
  task end_sim;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // About 750 cycles of work; 4,000 leaves room for refresh stalls
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    end_sim;
  end
  initial begin
    repeat (3) @(posedge clk_i);
    #2;
    rst_i = 1'b0;
    for (n0 = 0; n0 < 400 && init_done_o !== 1'b1; n0 = n0 + 1)
      @(posedge clk_i);
    chk("init", {15'h0000, init_done_o === 1'b1 && mdl_u.cbr_cnt >= 8}, 16'h0001);
    t_word;
    t_page;
    t_ref;
    t_self;
    end_sim;
  end
endmodule
